// ==== logic/pep_pkg.sv ====
// Shared constants and types for the parallel EEPROM page-write host
package pep_pkg;

  // ********************************************************************
  // Widths and field positions
  // ********************************************************************
  localparam int ADDR_W = 15; // Address lines
  localparam int DATA_W = 8; // Data lines
  localparam int PAGE_LSB = 6; // Lowest page_select_bits line
  localparam int PAGE_W = ADDR_W - PAGE_LSB; // Width of page_select_bits
  localparam int TOGGLE_BIT = 6; // Position of toggle_status_bit
  localparam int CNT_W = 22; // Width of every timer
  localparam logic [6:0] PAGE_BYTES = 7'h40; // Bytes per page latch

  // ********************************************************************
  // Timing, printed figures and derived cycle counts
  // ********************************************************************
  localparam int CLK_MHZ = 200; // System clock rate
  localparam int TWP_NS = 200; // Least write pulse width
  localparam int TWPH_NS = 100; // Least write pulse high time
  localparam int TACC_NS = 200; // Longest access time
  localparam int TOEHP_NS = 150; // Least strobe high time between polls
  localparam int BYTE_LOAD_WINDOW_US = 150; // byte_load_window, longest
  localparam int TWC_MS = 10; // program_cycle_time, longest
  localparam int SYNC_DEPTH = 3; // Flops in the data input synchroniser

  // Least times round up to whole cycles
  localparam logic [CNT_W-1:0] TWP_CYC =
    CNT_W'((TWP_NS * CLK_MHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] TWPH_CYC =
    CNT_W'((TWPH_NS * CLK_MHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] TOEHP_CYC =
    CNT_W'((TOEHP_NS * CLK_MHZ + 999) / 1000);
  // Read wait covers access time, the synchroniser and its agree stage,
  // plus one cycle so the first flop never samples on the access edge
  localparam logic [CNT_W-1:0] RD_CYC =
    CNT_W'((TACC_NS * CLK_MHZ + 999) / 1000 + SYNC_DEPTH + 2);
  // Window is a longest time, so it rounds down
  localparam int BLC_CYC_DEF = BYTE_LOAD_WINDOW_US * CLK_MHZ;
  // Poll timeout must not cut a legal program cycle short
  localparam int PROG_CYC_DEF = TWC_MS * 1000 * CLK_MHZ;

  // ********************************************************************
  // Unlock sequence of software_write_lock (set to the target's codes)
  // ********************************************************************
  localparam logic [ADDR_W-1:0] UNLOCK_ADDR0 = 15'h0001;
  localparam logic [ADDR_W-1:0] UNLOCK_ADDR1 = 15'h0002;
  localparam logic [ADDR_W-1:0] UNLOCK_ADDR2 = 15'h0003;
  localparam logic [DATA_W-1:0] UNLOCK_DATA0 = 8'h01;
  localparam logic [DATA_W-1:0] UNLOCK_DATA1 = 8'h02;
  localparam logic [DATA_W-1:0] UNLOCK_DATA2 = 8'h03;

  // ********************************************************************
  // Controller states, Gray coded along the write and poll path
  // ********************************************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_WPULSE = 3'h1,
    ST_WREC = 3'h3,
    ST_GAP = 3'h2,
    ST_PRD = 3'h6,
    ST_PREC = 3'h7,
    ST_READ = 3'h4
  } pep_state_e;

  // Page number of an address
  function automatic logic [PAGE_W-1:0] page_of(input logic [ADDR_W-1:0] a);
    page_of = a[ADDR_W-1:PAGE_LSB];
  endfunction : page_of

  // Address of unlock step idx
  function automatic logic [ADDR_W-1:0] unlock_addr(input logic [1:0] idx);
    unlock_addr = (idx == 2'h0) ? UNLOCK_ADDR0 :
                  (idx == 2'h1) ? UNLOCK_ADDR1 : UNLOCK_ADDR2;
  endfunction : unlock_addr

  // Data byte of unlock step idx
  function automatic logic [DATA_W-1:0] unlock_data(input logic [1:0] idx);
    unlock_data = (idx == 2'h0) ? UNLOCK_DATA0 :
                  (idx == 2'h1) ? UNLOCK_DATA1 : UNLOCK_DATA2;
  endfunction : unlock_data

endpackage : pep_pkg

// ==== logic/pep_pin_sync.sv ====
// Three-flop synchroniser for the data pins read back from the memory
`timescale 1ns/1ps

module pep_pin_sync
#(
  parameter int W = 8
)
(
  clk_sys,
  sys_rst,
  pinIn,
  pinOut
);
  input wire logic clk_sys;
  input wire logic sys_rst;
  input wire logic [W-1:0] pinIn;
  output logic [W-1:0] pinOut;

  // ********************************************************************
  // Per-bit chain
  // ********************************************************************
  logic [W-1:0] s1_q; // First stage, read only by the second
  logic [W-1:0] s2_q; // Second stage
  logic [W-1:0] s3_q; // Third stage
  logic [W-1:0] held_q; // Accepted level
  logic [W-1:0] held_d; // Next accepted level

  genvar gi;
  generate
    for (gi = 0; gi < W; gi++)
    begin : g_bit
      // A change counts only once two settled stages agree
      always_comb
      begin
        held_d[gi] = (s2_q[gi] == s3_q[gi]) ? s2_q[gi] : held_q[gi];
      end
    end
  endgenerate

  // Register the chain; async reset to constants only
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      held_q <= '0;
    end
    else
    begin
      s1_q <= pinIn;
      s2_q <= s1_q;
      s3_q <= s2_q;
      held_q <= held_d;
    end
  end

  assign pinOut = held_q;

endmodule : pep_pin_sync

// ==== logic/pep_host_ctrl.sv ====
// Host controller driving a parallel page-write EEPROM over its pins
// Operation
// RULE_01 - Next byte within byte_load_window of previous
// RULE_02 - Device latches one to sixty-four bytes
// RULE_03 - Keep page_select_bits fixed through one load
// RULE_04 - Device relocks after every program cycle
// RULE_05 - First three bytes go to unlock addresses
// RULE_06 - Output enable high only under both strobes
// RULE_07 - Device flips toggle_status_bit per read strobe
// RULE_08 - Done only when toggle_status_bit stops changing
// RULE_09 - Poll reads keep one fixed address
// RULE_10 - Unlock codes are byte data, 15-bit addresses
// RULE_11 - Device drives data only on read decode
// RULE_12 - Device latches address late, data early
// RULE_13 - Device inverts top bit while programming
// RULE_14 - Unlocked-less write only runs the timer
// RULE_15 - Loads ignored until program cycle ends
// RULE_16 - Device floats outputs outside read decode
`timescale 1ns/1ps

module pep_host_ctrl
#(
  parameter int BLC_CYC = pep_pkg::BLC_CYC_DEF, // Window in cycles
  parameter int PROG_CYC = pep_pkg::PROG_CYC_DEF // Poll timeout
)
(
  clk_sys,
  sys_rst,
  reqValid,
  reqWrite,
  reqAddr,
  reqData,
  reqLast,
  reqReady_q,
  rdValid_q,
  rdData_q,
  wrDone_q,
  wrTimeout_q,
  memAddr_q,
  ceN_q,
  oeN_q,
  weN_q,
  dqOut_q,
  dqDriveN_q,
  dqIn
);
  input wire logic clk_sys;
  input wire logic sys_rst;
  input wire logic reqValid;
  input wire logic reqWrite;
  input wire logic [pep_pkg::ADDR_W-1:0] reqAddr;
  input wire logic [pep_pkg::DATA_W-1:0] reqData;
  input wire logic reqLast;
  output logic reqReady_q;
  output logic rdValid_q;
  output logic [pep_pkg::DATA_W-1:0] rdData_q;
  output logic wrDone_q;
  output logic wrTimeout_q;
  output logic [pep_pkg::ADDR_W-1:0] memAddr_q;
  output logic ceN_q;
  output logic oeN_q;
  output logic weN_q;
  output logic [pep_pkg::DATA_W-1:0] dqOut_q;
  output logic dqDriveN_q;
  input wire logic [pep_pkg::DATA_W-1:0] dqIn;

  // ********************************************************************
  // State
  // ********************************************************************
  localparam logic [pep_pkg::CNT_W-1:0] BLC_LIM = pep_pkg::CNT_W'(BLC_CYC);
  localparam logic [pep_pkg::CNT_W-1:0] PROG_LIM =
    pep_pkg::CNT_W'(PROG_CYC);
  localparam logic [pep_pkg::CNT_W-1:0] ONE = 22'h000001;
  // Last count of a read access
  localparam logic [pep_pkg::CNT_W-1:0] RD_LAST = pep_pkg::RD_CYC - ONE;

  pep_pkg::pep_state_e st_q, st_d; // Sequencer
  logic [pep_pkg::CNT_W-1:0] cnt_q, cnt_d; // Phase timer
  logic [pep_pkg::CNT_W-1:0] winCnt_q, winCnt_d; // Since last WE fall
  logic [pep_pkg::CNT_W-1:0] progCnt_q, progCnt_d; // Poll time spent
  logic [1:0] unlockIdx_q, unlockIdx_d; // 0..2 unlock, 3 page data
  logic [6:0] byteCnt_q, byteCnt_d; // Page bytes sent
  logic closed_q, closed_d; // No more bytes in this load
  logic havePrev_q, havePrev_d; // A poll sample is held
  logic prevTog_q, prevTog_d; // Last toggle_status_bit sample
  logic [pep_pkg::ADDR_W-1:0] holdAddr_q, holdAddr_d; // Last byte addr
  logic [pep_pkg::DATA_W-1:0] holdData_q, holdData_d; // First data byte
  logic [pep_pkg::PAGE_W-1:0] pageSel_q, pageSel_d; // Locked page
  logic reqReady_d, rdValid_d, wrDone_d, wrTimeout_d;
  logic [pep_pkg::DATA_W-1:0] rdData_d;
  logic [pep_pkg::ADDR_W-1:0] memAddr_d;
  logic ceN_d, oeN_d, weN_d, dqDriveN_d;
  logic [pep_pkg::DATA_W-1:0] dqOut_d;
  logic [pep_pkg::DATA_W-1:0] dqSync; // Settled data pins
  logic take; // Request handshake
  logic samePage; // Request stays on the locked page

  // Data pins arrive from another timing world
  pep_pin_sync #(.W(pep_pkg::DATA_W)) u_sync
  (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .pinIn(dqIn),
    .pinOut(dqSync)
  );

  assign take = reqValid && reqReady_q;
  assign samePage = pep_pkg::page_of(reqAddr) == pageSel_q;

  // ********************************************************************
  // Next-state logic
  // ********************************************************************
  always_comb
  begin
    logic openPulse; // Start a write pulse this edge
    logic [pep_pkg::ADDR_W-1:0] nextAddr;
    logic [pep_pkg::DATA_W-1:0] nextData;
    openPulse = 1'b0;
    nextAddr = memAddr_q;
    nextData = dqOut_q;
    st_d = st_q;
    cnt_d = cnt_q + ONE;
    // Saturate so a stuck window still reads as lapsed
    winCnt_d = (winCnt_q < BLC_LIM) ? winCnt_q + ONE : winCnt_q;
    progCnt_d = progCnt_q;
    unlockIdx_d = unlockIdx_q;
    byteCnt_d = byteCnt_q;
    closed_d = closed_q;
    havePrev_d = havePrev_q;
    prevTog_d = prevTog_q;
    holdAddr_d = holdAddr_q;
    holdData_d = holdData_q;
    pageSel_d = pageSel_q;
    reqReady_d = reqReady_q;
    rdValid_d = 1'b0;
    rdData_d = rdData_q;
    wrDone_d = 1'b0;
    wrTimeout_d = 1'b0;
    memAddr_d = memAddr_q;
    ceN_d = ceN_q;
    oeN_d = oeN_q;
    weN_d = weN_q;
    dqOut_d = dqOut_q;
    dqDriveN_d = dqDriveN_q;
    unique case (st_q)
      pep_pkg::ST_IDLE:
      begin
        reqReady_d = 1'b1;
        if (take)
        begin
          reqReady_d = 1'b0;
          holdAddr_d = reqAddr;
          holdData_d = reqData;
          if (reqWrite)
          begin
            // Every write opens with the unlock bytes [RULE_05] [RULE_10]
            unlockIdx_d = 2'h0;
            closed_d = reqLast;
            nextAddr = pep_pkg::unlock_addr(2'h0);
            nextData = pep_pkg::unlock_data(2'h0);
            openPulse = 1'b1;
          end
          else
          begin
            // Plain read: chip and output enable low, write high
            memAddr_d = reqAddr;
            ceN_d = 1'b0;
            cnt_d = '0;
            st_d = pep_pkg::ST_READ;
          end
        end
      end
      pep_pkg::ST_WPULSE:
      begin
        // Strobes rise together; OE drops at the same edge [RULE_06]
        if (cnt_q >= pep_pkg::TWP_CYC - ONE)
        begin
          ceN_d = 1'b1;
          weN_d = 1'b1;
          oeN_d = 1'b0;
          // Data stays driven through recovery, so the latch has hold
          cnt_d = '0;
          st_d = pep_pkg::ST_WREC;
        end
      end
      pep_pkg::ST_WREC:
      begin
        if (cnt_q >= pep_pkg::TWPH_CYC - ONE)
        begin
          if (unlockIdx_q == 2'h2)
          begin
            // Unlock done, first page byte locks the page [RULE_03]
            unlockIdx_d = 2'h3;
            nextAddr = holdAddr_q;
            nextData = holdData_q;
            pageSel_d = pep_pkg::page_of(holdAddr_q);
            byteCnt_d = 7'h01;
            openPulse = 1'b1;
          end
          else if (unlockIdx_q != 2'h3)
          begin
            // Unlock steps in fixed order [RULE_05] [RULE_10]
            unlockIdx_d = unlockIdx_q + 2'h1;
            nextAddr = pep_pkg::unlock_addr(unlockIdx_q + 2'h1);
            nextData = pep_pkg::unlock_data(unlockIdx_q + 2'h1);
            openPulse = 1'b1;
          end
          else
          begin
            // Release the data pins once the last pulse has recovered
            dqDriveN_d = 1'b1;
            closed_d = closed_q || (byteCnt_q == pep_pkg::PAGE_BYTES);
            reqReady_d = !closed_q && (byteCnt_q != pep_pkg::PAGE_BYTES);
            st_d = pep_pkg::ST_GAP;
          end
        end
      end
      pep_pkg::ST_GAP:
      begin
        // Ready falls early so no byte lands past the window [RULE_01]
        reqReady_d = !closed_q && (winCnt_q < BLC_LIM - ONE - ONE);
        if (winCnt_q >= BLC_LIM)
        begin
          // Window lapsed: the device is programming now
          reqReady_d = 1'b0;
          memAddr_d = holdAddr_q; // Poll one fixed address [RULE_09]
          ceN_d = 1'b0;
          cnt_d = '0;
          progCnt_d = '0;
          havePrev_d = 1'b0;
          st_d = pep_pkg::ST_PRD;
        end
        else if (take && reqWrite && samePage && !closed_q)
        begin
          // Next byte of the same page [RULE_01] [RULE_03]
          reqReady_d = 1'b0;
          holdAddr_d = reqAddr;
          nextAddr = reqAddr;
          nextData = reqData;
          byteCnt_d = byteCnt_q + 7'h01;
          closed_d = reqLast;
          openPulse = 1'b1;
        end
        else if (take)
        begin
          // Read or other page: end the load, the request is dropped [RULE_03]
          reqReady_d = 1'b0;
          closed_d = 1'b1;
        end
      end
      pep_pkg::ST_PRD:
      begin
        progCnt_d = progCnt_q + ONE;
        if (cnt_q >= RD_LAST)
        begin
          ceN_d = 1'b1;
          cnt_d = '0;
          // Only an unchanged bit means done, never its value [RULE_08]
          if (havePrev_q && dqSync[pep_pkg::TOGGLE_BIT] == prevTog_q)
          begin
            wrDone_d = 1'b1;
            reqReady_d = 1'b1;
            st_d = pep_pkg::ST_IDLE;
          end
          else if (progCnt_q >= PROG_LIM)
          begin
            // Give up: the device never settled
            wrTimeout_d = 1'b1;
            reqReady_d = 1'b1;
            st_d = pep_pkg::ST_IDLE;
          end
          else
          begin
            prevTog_d = dqSync[pep_pkg::TOGGLE_BIT];
            havePrev_d = 1'b1;
            st_d = pep_pkg::ST_PREC;
          end
        end
      end
      pep_pkg::ST_PREC:
      begin
        // Toggle via chip enable; OE may not rise outside a write
        progCnt_d = progCnt_q + ONE;
        if (cnt_q >= pep_pkg::TOEHP_CYC - ONE)
        begin
          ceN_d = 1'b0;
          cnt_d = '0;
          st_d = pep_pkg::ST_PRD;
        end
      end
      pep_pkg::ST_READ:
      begin
        if (cnt_q >= RD_LAST)
        begin
          rdData_d = dqSync;
          rdValid_d = 1'b1;
          ceN_d = 1'b1;
          reqReady_d = 1'b1;
          st_d = pep_pkg::ST_IDLE;
        end
      end
      default:
      begin
        st_d = pep_pkg::ST_IDLE;
      end
    endcase
    if (openPulse)
    begin
      // WE, CE fall and OE rises in one edge [RULE_06]
      memAddr_d = nextAddr;
      dqOut_d = nextData;
      ceN_d = 1'b0;
      weN_d = 1'b0;
      oeN_d = 1'b1;
      dqDriveN_d = 1'b0;
      cnt_d = '0;
      winCnt_d = '0;
      st_d = pep_pkg::ST_WPULSE;
    end
  end

  // ********************************************************************
  // Registers
  // ********************************************************************
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_q <= pep_pkg::ST_IDLE;
      cnt_q <= '0;
      winCnt_q <= '0;
      progCnt_q <= '0;
      unlockIdx_q <= 2'h0;
      byteCnt_q <= 7'h00;
      closed_q <= 1'b0;
      havePrev_q <= 1'b0;
      prevTog_q <= 1'b0;
      holdAddr_q <= '0;
      holdData_q <= '0;
      pageSel_q <= '0;
      reqReady_q <= 1'b0;
      rdValid_q <= 1'b0;
      rdData_q <= '0;
      wrDone_q <= 1'b0;
      wrTimeout_q <= 1'b0;
      memAddr_q <= '0;
      ceN_q <= 1'b1;
      oeN_q <= 1'b0;
      weN_q <= 1'b1;
      dqOut_q <= '0;
      dqDriveN_q <= 1'b1;
    end
    else
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      winCnt_q <= winCnt_d;
      progCnt_q <= progCnt_d;
      unlockIdx_q <= unlockIdx_d;
      byteCnt_q <= byteCnt_d;
      closed_q <= closed_d;
      havePrev_q <= havePrev_d;
      prevTog_q <= prevTog_d;
      holdAddr_q <= holdAddr_d;
      holdData_q <= holdData_d;
      pageSel_q <= pageSel_d;
      reqReady_q <= reqReady_d;
      rdValid_q <= rdValid_d;
      rdData_q <= rdData_d;
      wrDone_q <= wrDone_d;
      wrTimeout_q <= wrTimeout_d;
      memAddr_q <= memAddr_d;
      ceN_q <= ceN_d;
      oeN_q <= oeN_d;
      weN_q <= weN_d;
      dqOut_q <= dqOut_d;
      dqDriveN_q <= dqDriveN_d;
    end
  end

  // ********************************************************************
  // Checks on the pins we drive
  // ********************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence seqPulseOpen;
    $fell(weN_q) && !ceN_q && oeN_q && !dqDriveN_q;
  endsequence

  AST_BYTE_GAP: assert property ( // [RULE_01]
    $fell(weN_q) && unlockIdx_q != 2'h0 |-> $past(winCnt_q) < BLC_LIM)
    else $error("write strobes spaced beyond the byte window");
  AST_WINDOW_CLOSE: assert property ( // [RULE_01]
    st_q == pep_pkg::ST_GAP && winCnt_q >= BLC_LIM
    |=> st_q == pep_pkg::ST_PRD && !ceN_q && weN_q)
    else $error("poll did not start when the window lapsed");
  AST_PAGE_HOLD: assert property ( // [RULE_03]
    $fell(weN_q) && unlockIdx_q == 2'h3
    |-> memAddr_q[pep_pkg::ADDR_W-1:pep_pkg::PAGE_LSB] == pageSel_q)
    else $error("page changed inside a load");
  AST_UNLOCK_STEP: assert property ( // [RULE_05]
    $fell(weN_q) && unlockIdx_q != 2'h3
    |-> memAddr_q == pep_pkg::unlock_addr(unlockIdx_q)
        && $past(st_q) != pep_pkg::ST_GAP)
    else $error("unlock byte at wrong address or out of order");
  AST_UNLOCK_DATA: assert property ( // [RULE_10]
    $fell(weN_q) && unlockIdx_q != 2'h3
    |-> dqOut_q == pep_pkg::unlock_data(unlockIdx_q))
    else $error("unlock byte carries wrong code");
  AST_OE_ONLY_IN_WRITE: assert property ( // [RULE_06]
    oeN_q |-> !weN_q && !ceN_q)
    else $error("output enable high outside a write pulse");
  AST_PULSE_SHAPE: assert property ( // [RULE_06]
    seqPulseOpen |=> (!weN_q && oeN_q && !ceN_q)[*8])
    else $error("write pulse too short");
  AST_DONE_STABLE: assert property ( // [RULE_08]
    wrDone_q |-> $past(havePrev_q)
      && $past(dqSync[pep_pkg::TOGGLE_BIT]) == prevTog_q)
    else $error("done without two equal toggle samples");
  AST_POLL_ADDR: assert property ( // [RULE_09]
    st_q == pep_pkg::ST_PRD && $past(st_q) == pep_pkg::ST_PREC
    |-> $stable(memAddr_q) && memAddr_q == holdAddr_q)
    else $error("poll address moved");

endmodule : pep_host_ctrl

// ==== testbench/pep_eeprom_model.sv ====
// Behavioural model of the page-write memory on the far side of the pins
`timescale 1ns/1ps

module pep_eeprom_model
#(
  parameter int WIN_NS = 600 // Byte load window, inside the host's own
)
(
  addr,
  ceN,
  oeN,
  weN,
  dqBus,
  progNs,
  dqMem,
  ruleErr
);
  input wire logic [14:0] addr;
  input wire logic ceN;
  input wire logic oeN;
  input wire logic weN;
  input wire logic [7:0] dqBus; // Resolved data lines
  input wire logic [31:0] progNs; // Program cycle length, set per test
  output logic [7:0] dqMem; // What the memory puts on the lines
  output int ruleErr; // Count of host protocol slips
  logic [7:0] mem [0:32767]; // Array contents
  logic [7:0] pend [int]; // Page latch, keyed by address
  logic [14:0] la, lastA, pollA;
  logic [8:0] pg;
  logic [7:0] lastD;
  logic loading = 1'b0, busy = 1'b0, tog = 1'b0;
  int step = 0, nPoll = 0;
  realtime tLoad, tEnd, tRd;
  // Case equality keeps unknown pins at start-up from faking a strobe
  wire wr = (ceN === 1'b0) && (weN === 1'b0) && (oeN === 1'b1);
  wire rd = (ceN === 1'b0) && (oeN === 1'b0) && (weN === 1'b1);

  // Unlock step s matches address and byte
  function automatic logic key(input int s, input logic [14:0] a,
                               input logic [7:0] d);
    key = (s == 0) ? (a == pep_pkg::UNLOCK_ADDR0 && d == pep_pkg::UNLOCK_DATA0)
        : (s == 1) ? (a == pep_pkg::UNLOCK_ADDR1 && d == pep_pkg::UNLOCK_DATA1)
        : (a == pep_pkg::UNLOCK_ADDR2 && d == pep_pkg::UNLOCK_DATA2);
  endfunction : key

  initial
  begin
    dqMem = 8'h5a;
    foreach (mem[i]) mem[i] = 8'hff;
  end

  // Address on the later falling strobe
  always @(posedge wr) la = addr;

  // Data on the earlier rising strobe; loads while busy are dropped
  always @(negedge wr)
  begin
    if (!busy && (loading || step == 3))
    begin
      if (loading && la[14:6] != pg) ruleErr++;
      pg = la[14:6];
      pend[la] = dqBus;
      lastA = la;
      lastD = dqBus;
      loading = 1'b1;
      tLoad = $realtime;
    end
    else if (!busy && key(step, la, dqBus)) step++;
    else if (!busy) // Unprotected write runs the timer only
    begin
      step = 0;
      busy = 1'b1;
      nPoll = 0;
      tEnd = $realtime + progNs;
    end
  end

  // Window, program timer and output drive, 1 ns resolution
  always #1
  begin
    if (loading && $realtime - tLoad > WIN_NS)
    begin
      foreach (pend[a]) mem[a] = pend[a];
      pend.delete();
      loading = 1'b0;
      step = 0;
      busy = 1'b1;
      nPoll = 0;
      tEnd = $realtime + progNs;
    end
    if (busy && $realtime >= tEnd) busy = 1'b0;
    // Floating or not yet valid lines show a moving pattern, not old data
    if (!rd || $realtime - tRd < 200) dqMem = ~dqMem;
    else if (!busy) dqMem = mem[addr];
    else dqMem = {addr == lastA ? ~lastD[7] : 1'b0, tog, mem[addr][5:0]};
  end

  // Each read strobe while busy flips the status bit
  always @(posedge rd)
  begin
    tRd = $realtime;
    tog = tog ^ busy;
    if (busy && nPoll > 0 && addr != pollA) ruleErr++;
    nPoll++;
    pollA = addr;
  end

  // Output enable may sit high only inside a write pulse
  always @(ceN or oeN or weN)
    #1 if (oeN === 1'b1 && !(ceN === 1'b0 && weN === 1'b0)) ruleErr++;
endmodule : pep_eeprom_model

// ==== testbench/tb_pep_host_ctrl.sv ====
// Self-checking bench for the page-write host controller
`timescale 1ns/1ps

module tb_pep_host_ctrl;
  localparam int BLC = 200; // Short load window for simulation
  localparam int PROG = 2000; // Short poll limit
  typedef struct packed {
    logic [14:0] a; // First address
    logic [7:0] d; // First byte, later bytes count up
    logic [6:0] n; // Bytes in the load
    logic [15:0] p; // Program time in ns
    logic to; // Expected poll timeout
  } pep_row_s;
  localparam pep_row_s ROWS [4] = '{
    '{15'h0000, 8'ha5, 7'h01, 16'h0fa0, 1'b0},
    '{15'h0040, 8'h10, 7'h40, 16'h0fa0, 1'b0},
    '{15'h0101, 8'h80, 7'h02, 16'h4e20, 1'b1},
    '{15'h7fc1, 8'h7e, 7'h03, 16'h0fa0, 1'b0}};
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic reqValid = 1'b0, reqWrite = 1'b0, reqLast = 1'b0;
  logic [14:0] reqAddr = 15'h0000;
  logic [7:0] reqData = 8'h00;
  logic reqReady_q, rdValid_q, wrDone_q, wrTimeout_q;
  logic ceN_q, oeN_q, weN_q, dqDriveN_q;
  logic [7:0] rdData_q, dqOut_q, dqMem, rdSeen;
  logic [14:0] memAddr_q;
  logic [31:0] progNs = 32'h0fa0;
  wire logic [7:0] dqIn;
  int ruleErr, err_total, n_checks, nEnd, nTo, nRd;

  pep_host_ctrl #(.BLC_CYC(BLC), .PROG_CYC(PROG)) dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .reqValid(reqValid),
    .reqWrite(reqWrite), .reqAddr(reqAddr), .reqData(reqData),
    .reqLast(reqLast), .reqReady_q(reqReady_q), .rdValid_q(rdValid_q),
    .rdData_q(rdData_q), .wrDone_q(wrDone_q), .wrTimeout_q(wrTimeout_q),
    .memAddr_q(memAddr_q), .ceN_q(ceN_q), .oeN_q(oeN_q), .weN_q(weN_q),
    .dqOut_q(dqOut_q), .dqDriveN_q(dqDriveN_q), .dqIn(dqIn));

  pep_eeprom_model mem (
    .addr(memAddr_q), .ceN(ceN_q), .oeN(oeN_q), .weN(weN_q),
    .dqBus(dqIn), .progNs(progNs), .dqMem(dqMem), .ruleErr(ruleErr));

  always #2.5 clk_sys = ~clk_sys;
  // Host drives when its enable is low, else the memory's lines
  assign dqIn = (dqDriveN_q === 1'b0) ? dqOut_q : dqMem;

  // Count the one-cycle result pulses
  always @(posedge clk_sys)
  begin
    if (wrDone_q === 1'b1 || wrTimeout_q === 1'b1) nEnd++;
    if (wrTimeout_q === 1'b1) nTo++;
    if (rdValid_q === 1'b1) rdSeen = rdData_q;
    if (rdValid_q === 1'b1) nRd++;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  // Present one request and hold it until the edge that takes it
  task automatic req(input logic w, input logic [14:0] a,
                     input logic [7:0] d, input logic l);
    int n;
    n = 0;
    reqValid = 1'b1;
    reqWrite = w;
    reqAddr = a;
    reqData = d;
    reqLast = l;
    // Ready is read once settled; the following edge takes the request
    while (reqReady_q !== 1'b1 && n < 40000)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    @(posedge clk_sys);
    #1;
    chk(8'(n < 40000), 8'h01);
  endtask : req

  // Bounded wait until a pulse counter reaches its target
  task automatic waitFor(ref int c, input int tgt);
    int n;
    n = 0;
    while (c < tgt && n < 40000)
    begin
      @(posedge clk_sys);
      n++;
    end
    #1;
    chk(8'(c >= tgt), 8'h01);
  endtask : waitFor

  task automatic rdChk(input logic [14:0] a, input logic [7:0] exp);
    int k;
    k = nRd;
    req(1'b0, a, 8'h00, 1'b0);
    reqValid = 1'b0;
    waitFor(nRd, k + 1);
    chk(rdSeen, exp);
  endtask : rdChk

  // Watchdog, several times the expected run length
  initial
  begin
    #400000;
    err_total++;
    $display("[FAIL] %0t watchdog expired", $time);
    stop_test();
  end

  initial
  begin
    int i, e, t, r;
    repeat (2) @(posedge clk_sys);
    #1 sys_rst = 1'b0;
    @(posedge clk_sys);
    #1;
    // Ordinary page loads, then readback of every byte
    for (r = 0; r < 4; r++)
    begin
      progNs = {16'h0000, ROWS[r].p};
      e = nEnd;
      t = nTo;
      for (i = 0; i < ROWS[r].n; i++)
        req(1'b1, ROWS[r].a + 15'(i), ROWS[r].d + 8'(i), i == ROWS[r].n - 1);
      reqValid = 1'b0;
      waitFor(nEnd, e + 1);
      chk(8'(nTo - t), {7'h00, ROWS[r].to});
      #(ROWS[r].p);
      @(posedge clk_sys);
      #1;
      for (i = 0; i < ROWS[r].n; i++)
        rdChk(ROWS[r].a + 15'(i), ROWS[r].d + 8'(i));
      $display("row %0d done", r);
    end
    // Second reset in mid-run: pins park, ready returns
    sys_rst = 1'b1;
    @(posedge clk_sys);
    #1;
    chk({ceN_q, weN_q, oeN_q, dqDriveN_q, reqReady_q, 3'h0}, 8'hd0);
    sys_rst = 1'b0;
    @(posedge clk_sys);
    #1;
    chk({7'h00, reqReady_q}, 8'h01);
    rdChk(15'h0000, 8'ha5);
    $display("reset test done");
    // Other page in the load gap ends the load and is not written;
    // it has to be sent again as a fresh load
    progNs = 32'h0fa0;
    e = nEnd;
    req(1'b1, 15'h0200, 8'h3c, 1'b0);
    req(1'b1, 15'h0240, 8'hc3, 1'b1);
    reqValid = 1'b0;
    waitFor(nEnd, e + 1);
    rdChk(15'h0240, 8'hff);
    req(1'b1, 15'h0240, 8'hc3, 1'b1);
    reqValid = 1'b0;
    waitFor(nEnd, e + 2);
    rdChk(15'h0200, 8'h3c);
    rdChk(15'h0240, 8'hc3);
    chk(8'(ruleErr), 8'h00);
    $display("page gap test done");
    stop_test();
  end
endmodule : tb_pep_host_ctrl
